// file: rtl/be_split.sv
// Maps eight processor byte enables onto one 32-bit local half.
`timescale 1ns/100ps
module be_split
  import cpu_glue_pkg::*;
(
  input  wire logic [CPU_BE_W-1:0] cpu_be_n,   // Processor byte enables, active low
  input  wire logic                second_pass, // Second local cycle of a split access
  output logic                     addr_bit2,  // Local address bit 2 for this pass
  output logic      [LOC_BE_W-1:0] half_be_n,  // Byte enables of the chosen half
  output logic                     needs_split // Both halves hold enabled bytes
);

  logic [LOC_BE_W-1:0] low_be_n;               // Bytes 3 to 0
  logic [LOC_BE_W-1:0] high_be_n;              // Bytes 7 to 4
  logic                low_used;               // Some low byte enabled
  logic                high_used;              // Some high byte enabled

  assign low_be_n  = cpu_be_n[LOC_BE_W-1:0];
  assign high_be_n = cpu_be_n[CPU_BE_W-1:LOC_BE_W];
  assign low_used  = ~&low_be_n;
  assign high_used = ~&high_be_n;

  // Low half goes first; the upper half follows on the second pass
  assign needs_split = low_used & high_used;
  assign addr_bit2   = second_pass | ~low_used;
  assign half_be_n   = addr_bit2 ? high_be_n : low_be_n;

endmodule

// file: rtl/cpu_glue_pkg.sv
// Shared constants, types and helper decode for the processor bus glue.
// How it works
// - Cycle type decoded from the three status bits
// - Address strobe starts each new bus cycle
// - Burst ready terminates every processor cycle
// - Next-address asserted for local memory cycles
// - Combined enable pin tells cycle cacheability
// - Same pin flags cacheable local memory cycle
// - Snoop strobe issued for external valid address
// - Same pin selects write-through in processor cycles
// - Coprocessor error drives interrupt request high
// - Clear-port write returns interrupt request low
// - Error input high restores ignore-error high
// - Modified hit prepares for line write-back
// - Cacheable local memory cycle means burst, reads only in a cacheable region
// - A20 mask from keyboard gate and port
// - Local address bit two from enables
// - Four local byte enables from eight
// - Split access spanning both halves in two
package cpu_glue_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int CPU_BE_W   = 8;              // Processor byte enables
  localparam int LOC_BE_W   = 4;              // Local byte enables
  localparam int IO_ADDR_W  = 13;             // Address bits 15:3 seen by the decode
  localparam int SYNC_STAGE = 2;              // Flip-flops in each pin synchroniser

  ////////////////////////////////////////////////////////////////////////////
  // Port decode: coprocessor clear port sits in byte lane 0 of word 0x1e
  localparam logic [IO_ADDR_W-1:0] FPU_CLEAR_WORD = 13'h001e; // Port f0h >> 3
  localparam int                   FPU_CLEAR_LANE = 0;        // Byte lane of port f0h

  ////////////////////////////////////////////////////////////////////////////
  // Transfer counts
  localparam logic [2:0] BURST_BEATS  = 3'h4; // Data phases in a line burst
  localparam logic [2:0] SINGLE_BEATS = 3'h1; // Data phases in a single transfer

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    cyc_int_ack,                              // Interrupt acknowledge
    cyc_special,                              // Halt, shutdown and the like
    cyc_io_read,                              // I/O read
    cyc_io_write,                             // I/O write
    cyc_code_read,                            // Instruction fetch
    cyc_reserved,                             // Undefined encoding
    cyc_mem_read,                             // Memory data read
    cyc_mem_write                             // Memory data write
  } cycle_t;

  // Status bits m_io, d_c, w_r in that order map straight onto cycle_t
  function automatic cycle_t decode_cycle(input logic m_io, input logic d_c,
                                          input logic w_r);
    decode_cycle = cycle_t'({m_io, d_c, w_r});
  endfunction

endpackage

// file: rtl/cpu_host_local_bus_glue.sv
// Processor bus cycle decode, termination and local bus byte-lane glue.
`timescale 1ns/100ps
module cpu_host_local_bus_glue
  import cpu_glue_pkg::*;
(
  input  wire logic                 clock,             // Master clock, 50 MHz
  input  wire logic                 resetn,            // Asynchronous reset, active low
  // Processor pins
  input  wire logic                 ads_n,             // Address strobe, active low
  input  wire logic                 m_io,              // Memory (1) or I/O (0)
  input  wire logic                 d_c,               // Data (1) or control (0)
  input  wire logic                 w_r,               // Write (1) or read (0)
  input  wire logic [CPU_BE_W-1:0]  be_n,              // Byte enables, active low
  input  wire logic [IO_ADDR_W-1:0] cpu_addr,          // Address bits 15:3
  input  wire logic                 ferr_n,            // Coprocessor error, active low
  input  wire logic                 hitm_n,            // Modified line hit, active low
  input  wire logic                 cache_n,           // Cacheable cycle, active low
  // Internal controller inputs on this clock
  input  wire logic                 cpu_owns_bus,      // Processor owns the bus
  input  wire logic                 local_mem_hit,     // Address hits local memory
  input  wire logic                 cacheable_region,  // Address may be cached
  input  wire logic                 mem_data_ready,    // Memory controller data phase done
  input  wire logic                 snoop_addr_valid,  // External agent drove an address
  input  wire logic                 write_through_req, // Use write-through for this line
  input  wire logic                 keyboard_a20_gate_state, // Emulated keyboard gate
  input  wire logic                 port92_a20_enable, // System control port bit 1
  // Local bus pins
  input  wire logic                 local_ready_n,     // Local cycle done, active low
  input  wire logic                 local_addr_bit2_i, // Address bit 2 pin level
  output logic                      local_addr_bit2_o, // Address bit 2 driven value
  output logic                      local_addr_bit2_oe,// Address bit 2 drive enable
  input  wire logic [LOC_BE_W-1:0]  local_byte_enable_n_i,  // Byte enable pin levels
  output logic      [LOC_BE_W-1:0]  local_byte_enable_n_o,  // Byte enables driven
  output logic                      local_byte_enable_n_oe, // Byte enable drive enable
  output logic                      local_start_n,     // Local cycle start, active low
  // Processor outputs
  output logic                      brdy_n,            // Burst ready, active low
  output logic                      na_n,              // Next address, active low
  output logic                      local_memory_cycle_n, // Cache enable / local memory
  output logic                      ext_addr_write_through_n, // Snoop strobe / write-through
  output logic                      fpu_irq,           // Coprocessor interrupt request
  output logic                      ignore_fpu_error_n,// Ignore coprocessor error
  output logic                      a20_mask_n,        // Address 20 mask, active low
  // Status towards the rest of the controller
  output logic                      writeback_pending, // Modified line write-back expected
  output logic                      burst_expected,    // Current cycle is a line burst
  output cycle_t                    cycle_type,        // Decoded type of current cycle
  output logic                      master_addr_bit2,  // Bit 2 seen in other-master cycles
  output logic      [LOC_BE_W-1:0]  master_byte_enable_n // Enables seen from other masters
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int CPU_SYNC_W = 6 + CPU_BE_W + IO_ADDR_W; // Processor pin group
  localparam int LOC_SYNC_W = 3 + LOC_BE_W;             // Cacheable, ready, bit 2, enables

  logic [CPU_SYNC_W-1:0] cpu_raw;              // Processor pins before sync
  logic [CPU_SYNC_W-1:0] cpu_sync;             // Processor pins after sync
  logic [LOC_SYNC_W-1:0] loc_raw;              // Local pins before sync
  logic [LOC_SYNC_W-1:0] loc_sync;             // Local pins after sync

  assign cpu_raw = {ads_n, m_io, d_c, w_r, ferr_n, hitm_n, be_n, cpu_addr};
  assign loc_raw = {cache_n, local_ready_n, local_addr_bit2_i, local_byte_enable_n_i};

  // Everything idles high; the first stage is read by nothing else
  pin_sync #(.WIDTH(CPU_SYNC_W), .RST_VAL(1'b1)) u_cpu_sync (
    .clock    (clock),
    .resetn   (resetn),
    .pin_in   (cpu_raw),
    .sync_out (cpu_sync)
  );

  pin_sync #(.WIDTH(LOC_SYNC_W), .RST_VAL(1'b1)) u_loc_sync (
    .clock    (clock),
    .resetn   (resetn),
    .pin_in   (loc_raw),
    .sync_out (loc_sync)
  );

  logic                 s_ads_n;               // Synced address strobe
  logic                 s_m_io;                // Synced memory/IO
  logic                 s_d_c;                 // Synced data/control
  logic                 s_w_r;                 // Synced write/read
  logic                 s_ferr_n;              // Synced coprocessor error
  logic                 s_hitm_n;              // Synced modified hit
  logic [CPU_BE_W-1:0]  s_be_n;                // Synced byte enables
  logic [IO_ADDR_W-1:0] s_addr;                // Synced address
  logic                 s_cache_n;             // Synced cacheable flag
  logic                 s_lrdy_n;              // Synced local ready
  logic                 s_la2;                 // Synced local bit 2
  logic [LOC_BE_W-1:0]  s_lbe_n;               // Synced local enables

  assign {s_ads_n, s_m_io, s_d_c, s_w_r, s_ferr_n, s_hitm_n, s_be_n, s_addr} = cpu_sync;
  assign {s_cache_n, s_lrdy_n, s_la2, s_lbe_n} = loc_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle decode

  typedef enum logic [2:0] {
    st_idle,                                   // Waiting for an address strobe
    st_mem,                                    // Local memory data phases
    st_start,                                  // Launch a local bus cycle
    st_local,                                  // Waiting for local ready
    st_done                                    // Final burst ready
  } state_t;

  state_t     state_q, state_d;                // Cycle sequencer
  cycle_t     cyc_q;                           // Type of cycle in progress
  logic [CPU_BE_W-1:0] be_q;                   // Enables latched at the strobe
  logic       second_q, second_d;              // Second pass of a split access
  logic [2:0] beats_q, beats_d;                // Data phases still owed

  wire  cycle_t new_cyc     = decode_cycle(s_m_io, s_d_c, s_w_r);
  wire  logic   new_start   = ~s_ads_n & cpu_owns_bus & (state_q == st_idle);
  wire  logic   is_mem      = (new_cyc == cyc_mem_read) | (new_cyc == cyc_mem_write)
                              | (new_cyc == cyc_code_read);
  wire  logic   mem_hit     = is_mem & local_mem_hit;
  wire  logic   cache_ok    = mem_hit & cacheable_region;
  wire  logic   is_burst    = ~s_cache_n & (s_w_r | cache_ok);
  wire  logic   clear_write = (new_cyc == cyc_io_write) & (s_addr == FPU_CLEAR_WORD)
                              & ~s_be_n[FPU_CLEAR_LANE];
  wire  logic   no_target   = (new_cyc == cyc_special) | (new_cyc == cyc_reserved)
                              | clear_write;

  // Byte lane mapping for the current pass
  logic                split_need;             // Both halves enabled
  logic                pass_la2;               // Bit 2 for this pass
  logic [LOC_BE_W-1:0] pass_be_n;              // Enables for this pass

  be_split u_be_split (
    .cpu_be_n    (be_q),
    .second_pass (second_q),
    .addr_bit2   (pass_la2),
    .half_be_n   (pass_be_n),
    .needs_split (split_need)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state: every path ends in a burst ready

  always_comb begin
    state_d  = state_q;
    second_d = second_q;
    beats_d  = beats_q;
    case (state_q)
      st_idle: begin
        second_d = 1'b0;
        if (new_start) begin
          if (no_target) begin
            state_d = st_done;
          end else if (mem_hit) begin
            state_d = st_mem;
            beats_d = is_burst ? BURST_BEATS : SINGLE_BEATS;
          end else begin
            state_d = st_start;
          end
        end
      end
      st_mem: begin
        if (mem_data_ready) begin
          beats_d = beats_q - SINGLE_BEATS;
          if (beats_q == SINGLE_BEATS) begin
            state_d = st_idle;
          end
        end
      end
      st_start: begin
        state_d = st_local;
      end
      st_local: begin
        if (!s_lrdy_n) begin
          if (split_need && !second_q) begin
            second_d = 1'b1;
            state_d  = st_start;
          end else begin
            state_d  = st_done;
          end
        end
      end
      st_done: begin
        state_d = st_idle;
      end
      default: begin
        state_d = st_idle;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q  <= st_idle;
      second_q <= 1'b0;
      beats_q  <= 3'h0;
    end else begin
      state_q  <= state_d;
      second_q <= second_d;
      beats_q  <= beats_d;
    end
  end

  // Cycle attributes latched at the strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cyc_q <= cyc_special;
      be_q  <= '1;
    end else if (new_start) begin
      cyc_q <= new_cyc;
      be_q  <= s_be_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Processor handshake outputs

  logic brdy_q;                                // Burst ready, active low
  logic na_q;                                  // Next address, active low
  logic ken_q;                                 // Cache enable / local memory
  logic ewt_q;                                 // Snoop strobe / write-through
  logic burst_q;                               // Burst expected

  wire logic brdy_d = ~(((state_q == st_mem) & mem_data_ready) | (state_d == st_done));

  // A snoop strobe only when the processor is off the bus; otherwise the pin
  // carries the write policy of the current processor cycle
  wire logic ewt_d  = cpu_owns_bus ? ~write_through_req
                                   : ~snoop_addr_valid;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      brdy_q  <= 1'b1;
      na_q    <= 1'b1;
      ken_q   <= 1'b1;
      ewt_q   <= 1'b1;
      burst_q <= 1'b0;
    end else begin
      brdy_q  <= brdy_d;
      na_q    <= ~(new_start & mem_hit);
      // Held for the whole cycle so the companion sees it as a level
      if (new_start) begin
        ken_q   <= ~cache_ok;
        burst_q <= is_burst & mem_hit;
      end else if (state_d == st_idle) begin
        ken_q   <= 1'b1;
        burst_q <= 1'b0;
      end
      ewt_q   <= ewt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coprocessor error handling

  logic irq_q;                                 // Interrupt request level
  logic ign_q;                                 // Ignore error, active low
  logic ferr_prev_q;                           // Error level one cycle ago

  wire logic ferr_fall   = ferr_prev_q & ~s_ferr_n;
  wire logic clear_event = new_start & clear_write;

  // A new error edge wins over a clear-port write in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_q       <= 1'b0;
      ign_q       <= 1'b1;
      ferr_prev_q <= 1'b1;
    end else begin
      ferr_prev_q <= s_ferr_n;
      if (ferr_fall) begin
        irq_q <= 1'b1;
      end else if (clear_event) begin
        irq_q <= 1'b0;
      end
      if (s_ferr_n) begin
        ign_q <= 1'b1;
      end else if (clear_event) begin
        ign_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate A20 and write-back preparation

  logic a20_q;                                 // Address 20 mask, active low
  logic wb_q;                                  // Write-back pending

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      a20_q <= 1'b0;
      wb_q  <= 1'b0;
    end else begin
      a20_q <= keyboard_a20_gate_state | port92_a20_enable;
      // Set during an inquire; the processor's next write is the line
      // write-back, so that strobe clears it, but a fresh hit wins
      if (!s_hitm_n) begin
        wb_q <= 1'b1;
      end else if (new_start && s_w_r) begin
        wb_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local bus lanes: driven in processor cycles, sampled otherwise

  logic                la2_q;                  // Driven bit 2
  logic [LOC_BE_W-1:0] lbe_q;                  // Driven enables
  logic                drv_q;                  // Drive enable for both
  logic                lstart_q;               // Local start, active low
  logic                m_la2_q;                // Sampled bit 2
  logic [LOC_BE_W-1:0] m_lbe_q;                // Sampled enables

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      la2_q    <= 1'b0;
      lbe_q    <= '1;
      drv_q    <= 1'b0;
      lstart_q <= 1'b1;
      m_la2_q  <= 1'b0;
      m_lbe_q  <= '1;
    end else begin
      drv_q    <= cpu_owns_bus;
      la2_q    <= pass_la2;
      lbe_q    <= pass_be_n;
      lstart_q <= ~(state_q == st_start);
      // Bus pins are inputs while another master owns them
      if (!cpu_owns_bus) begin
        m_la2_q <= s_la2;
        m_lbe_q <= s_lbe_n;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output wiring, all straight from flip-flops

  assign brdy_n                   = brdy_q;
  assign na_n                     = na_q;
  assign local_memory_cycle_n     = ken_q;
  assign ext_addr_write_through_n = ewt_q;
  assign fpu_irq                  = irq_q;
  assign ignore_fpu_error_n       = ign_q;
  assign a20_mask_n               = a20_q;
  assign writeback_pending        = wb_q;
  assign burst_expected           = burst_q;
  assign cycle_type               = cyc_q;
  assign local_addr_bit2_o        = la2_q;
  assign local_addr_bit2_oe       = drv_q;
  assign local_byte_enable_n_o    = lbe_q;
  assign local_byte_enable_n_oe   = drv_q;
  assign local_start_n            = lstart_q;
  assign master_addr_bit2         = m_la2_q;
  assign master_byte_enable_n     = m_lbe_q;

endmodule

// file: rtl/pin_sync.sv
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/100ps
module pin_sync
  import cpu_glue_pkg::*;
#(
  parameter int    WIDTH   = 1,               // Number of bits in the group
  parameter logic  RST_VAL = 1'b1             // Idle level of every bit
) (
  input  wire logic             clock,        // Master clock
  input  wire logic             resetn,       // Asynchronous reset, active low
  input  wire logic [WIDTH-1:0] pin_in,       // Raw pin levels
  output logic      [WIDTH-1:0] sync_out      // Levels after two flip-flops
);

  logic [WIDTH-1:0] meta_q;                   // First stage, read only by stage two
  logic [WIDTH-1:0] sync_q;                   // Second stage

  ////////////////////////////////////////////////////////////////////////////
  // One pair of flip-flops per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          meta_q[i] <= RST_VAL;
          sync_q[i] <= RST_VAL;
        end else begin
          meta_q[i] <= pin_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_q;

endmodule

// file: test/cpu_host_local_bus_glue_tb.sv
// Random and corner stimulus for the processor bus glue.
`timescale 1ns/100ps
module cpu_host_local_bus_glue_tb;
  import cpu_glue_pkg::*;
  logic clock = 0, resetn = 0, ads_n = 1, m_io = 0, d_c = 0, w_r = 0, ferr_n = 1, hitm_n = 1;
  logic cache_n = 1, cpu_owns_bus = 1, local_mem_hit = 0, cacheable_region = 0, slow = 0;
  logic mem_data_ready = 0, snoop_addr_valid = 0, write_through_req = 0, mon = 0, m_la2 = 0;
  logic keyboard_a20_gate_state = 0, port92_a20_enable = 0, local_addr_bit2_i, na_n, brdy_n;
  logic local_addr_bit2_o, local_addr_bit2_oe, local_byte_enable_n_oe, local_start_n, fpu_irq;
  logic local_ready_n, local_memory_cycle_n, ext_addr_write_through_n, ignore_fpu_error_n;
  logic a20_mask_n, writeback_pending, burst_expected, master_addr_bit2;
  logic [7:0] be_n = 8'hff;
  logic [12:0] cpu_addr = 13'h0000;
  logic [3:0] m_lbe = 4'h0, local_byte_enable_n_i, local_byte_enable_n_o, master_byte_enable_n;
  logic [4:0] pq[$];                 // Expected {bit2, enables} per local pass
  cycle_t cycle_type;
  int n_fail = 0, checks = 0;
  // Pin level: design drives in processor cycles, the other master otherwise
  assign local_addr_bit2_i = local_addr_bit2_oe ? local_addr_bit2_o : m_la2;
  assign local_byte_enable_n_i = local_byte_enable_n_oe ? local_byte_enable_n_o : m_lbe;
  cpu_host_local_bus_glue dut (.*);
  local_dev_model pdev (.*);
  initial forever #10 clock = ~clock;
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Memory phases and gate sources wander at random every cycle
  always @(posedge clock) begin
    #2;
    {mem_data_ready, keyboard_a20_gate_state, port92_a20_enable} = 3'($urandom);
    {snoop_addr_valid, write_through_req} = 2'($urandom);
  end
  // Each local start must show the next expected half, low half first
  always @(posedge clock) if (mon && !local_start_n)
    chk({local_addr_bit2_o, local_byte_enable_n_o}, pq.size() ? pq.pop_front() : 5'h1f);
  // One processor cycle: strobe, count ready pulses, then look for stragglers
  task automatic cyc(input logic [2:0] t, input logic [7:0] be, input logic [12:0] a);
    int got, want;
    logic [2:0] seen;
    logic mem, loc;
    got = 0;
    seen = 3'h0;
    mem = t[2] && t != 3'h5;
    // Everything but special, reserved, the clear port and local memory goes to the local bus
    loc = !(t == 3'h1 || t == 3'h5 || (t == 3'h3 && a == FPU_CLEAR_WORD && !be[0]))
          && !(mem && local_mem_hit);
    want = (mem && local_mem_hit && !cache_n && (t[0] || cacheable_region)) ? 4 : 1;
    if (loc && be[3:0] != 4'hf) pq.push_back({1'b0, be[3:0]});
    if (loc && be[7:4] != 4'hf) pq.push_back({1'b1, be[7:4]});
    {m_io, d_c, w_r} = t;
    be_n = be;
    cpu_addr = a;
    mon = loc;
    ads_n = 0;
    tick(1);
    ads_n = 1;
    for (int i = 0; i < 300 && got < want; i++) begin
      tick(1);
      got += !brdy_n;
      seen |= {burst_expected, !na_n, !local_memory_cycle_n};
    end
    if (got < want) begin
      n_fail++;
      print_verdict;
    end
    repeat (4) begin
      tick(1);
      got += !brdy_n;
    end
    chk(got, want);
    chk(seen, {want == 4, mem && local_mem_hit, mem && local_mem_hit && cacheable_region});
    chk(cycle_type, t);
    chk(pq.size(), 0);
    mon = 0;
  endtask
  initial begin
    void'($urandom(32'ha840c804));
    tick(10);
    resetn = 1;
    tick(2);
    cyc(3'h2, 8'h0f, 13'h0100);
    cyc(3'h3, 8'h00, 13'h0104);
    repeat (3) for (int t = 0; t < 8; t++) begin
      {local_mem_hit, cacheable_region, slow} = 3'($urandom);
      cache_n = !(local_mem_hit && t[2] && $urandom % 2);
      cyc(t, 8'($urandom) & 8'hbf, {5'h01, 8'($urandom)});
    end
    $display("cycle tests done");
    chk(ignore_fpu_error_n, 1);
    ferr_n = 0;
    tick(5);
    chk(fpu_irq, 1);
    cyc(3'h3, 8'hfe, FPU_CLEAR_WORD);
    chk({fpu_irq, ignore_fpu_error_n}, 0);
    ferr_n = 1;
    tick(4);
    chk(ignore_fpu_error_n, 1);
    hitm_n = 0;
    tick(1);
    hitm_n = 1;
    tick(4);
    chk(writeback_pending, 1);
    cyc(3'h7, 8'h00, 13'h0100);
    chk(writeback_pending, 0);
    $display("coprocessor and write-back tests done");
    cpu_owns_bus = 0;
    m_la2 = 1;
    m_lbe = 4'h5;
    tick(5);
    chk({local_addr_bit2_oe, local_byte_enable_n_oe}, 0);
    chk({master_addr_bit2, master_byte_enable_n}, 8'h15);
    cpu_owns_bus = 1;
    tick(3);
    $display("other master test done");
    print_verdict;
  end
endmodule

// file: test/glue_asserts.sv
// Port relation checks for the processor bus glue.
`timescale 1ns/100ps
module glue_asserts (
  input wire logic clock, resetn, ads_n, ferr_n, cpu_owns_bus, write_through_req,
  input wire logic snoop_addr_valid, keyboard_a20_gate_state, port92_a20_enable,
  input wire logic brdy_n, na_n, ext_addr_write_through_n, fpu_irq, ignore_fpu_error_n,
  input wire logic a20_mask_n, local_byte_enable_n_oe, local_start_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Registered outputs follow their sources one clock later, once out of reset
  a20_map_a: assert property ($past(resetn) |->
    a20_mask_n == $past(keyboard_a20_gate_state | port92_a20_enable)) else $error("a20");
  wt_select_a: assert property ($past(resetn) && $past(cpu_owns_bus) |->
    ext_addr_write_through_n == !$past(write_through_req)) else $error("wt");
  snoop_strobe_a: assert property ($past(resetn) && !$past(cpu_owns_bus) |->
    ext_addr_write_through_n == !$past(snoop_addr_valid)) else $error("snoop");
  be_drive_a: assert property ($past(resetn) |->
    local_byte_enable_n_oe == $past(cpu_owns_bus)) else $error("lbe drive");
  na_pulse_a: assert property (!na_n |=> na_n) else $error("na width");
  irq_set_a: assert property ($fell(ferr_n) |-> ##[1:4] fpu_irq) else $error("irq");
  ign_high_a: assert property (ferr_n [*4] |-> ignore_fpu_error_n) else $error("ign");
  cycle_end_a: assert property ($fell(ads_n) && cpu_owns_bus |-> ##[2:300] !brdy_n)
    else $error("no brdy");
  cover property (!na_n);
  cover property ($rose(fpu_irq));
  cover property (!local_start_n);
endmodule
bind cpu_host_local_bus_glue glue_asserts chk_i (.*);

// file: test/local_dev_model.sv
// Local bus device that answers each local cycle start.
`timescale 1ns/100ps
module local_dev_model (
  input  wire logic clock,         // Master clock
  input  wire logic local_start_n, // Cycle start, active low
  input  wire logic slow,          // Insert wait states
  output logic      local_ready_n  // Ready strobe, pulled up when idle
);
  int cnt = 0;                     // Cycles left until ready
  // One-cycle ready, early or late; idle line rests at the pull-up level
  always @(posedge clock) begin
    local_ready_n <= !(cnt == 1);
    cnt <= !local_start_n ? (slow ? 5 : 2) : (cnt > 0 ? cnt - 1 : 0);
  end
endmodule
